// *** pmrc_cfg.svh ***
// Purpose: Constants for the mode and reset supervisor.
// Assumes: 40 MHz clock, 25 ns period.
// Notes: Registers sit on APB at word-aligned byte offsets.
`ifndef PMRC_CFG_SVH
`define PMRC_CFG_SVH
`define PMRC_CLK_HZ 40000000
`define PMRC_OFS_CTRL 12'h000
`define PMRC_OFS_CMD 12'h004
`define PMRC_OFS_STAT 12'h008
`define PMRC_OFS_BKPT 12'h00c
`define PMRC_OFS_CYCLIM 12'h010
`define PMRC_OFS_CARD 12'h014
`define PMRC_OFS_FWVER 12'h018
`define PMRC_OFS_ANALOG 12'h01c
`define PMRC_OFS_MPA 12'h020
`define PMRC_MAX_BKPT 2'h3
`define PMRC_STEP_BKPT_MAX 2'h2
`define PMRC_WDOG_MS 100
`define PMRC_CYC_MIN_MS 1
`define PMRC_HOLD_WIPE_S 3
`define PMRC_TAP_MAX_S 3
`define PMRC_MPA_DEFAULT 8'h02
`define PMRC_FW_PREFIX 16'h7078
`define PMRC_CYC_MS_CYCLES (`PMRC_CLK_HZ / 1000)
`define PMRC_BLINK_CYCLES 10000000
`define PMRC_ERASE_CYCLES 64
`define PMRC_CMD_STEP 0
`define PMRC_CMD_RESUME 1
`define PMRC_CMD_WIPE 2
`define PMRC_CMD_FACTORY 3
`define PMRC_CMD_FWUPD 4
`define PMRC_CMD_BKHIT 5
`define PMRC_CMD_CYCDONE 6
`define PMRC_CMD_WDKICK 7
`define PMRC_CMD_RELOADED 8
`define PMRC_CMD_STARTDONE 9
`endif

// *** pmrc_pkg.sv ***
// Purpose: Types for the mode and reset supervisor.
// Assumes: Nothing beyond the header.
// Notes: One-hot state codes.
package pmrc_pkg;
    typedef enum logic [8:0] {
        ST_STOP = 9'h001,
        ST_STARTUP = 9'h002,
        ST_RUN = 9'h004,
        ST_HOLD = 9'h008,
        ST_ARM = 9'h010,
        ST_WAITTAP = 9'h020,
        ST_ERASE = 9'h040,
        ST_RELOAD = 9'h080,
        ST_FWUPD = 9'h100
    } pmrc_state_t;
    typedef enum logic [1:0] {
        SW_STOP = 2'h0,
        SW_RUN = 2'h1,
        SW_WIPE = 2'h2
    } pmrc_switch_t;
    typedef struct packed {
        logic runLed;
        logic stopLed;
        logic cardLed;
        logic fwLed;
    } pmrc_leds_t;
    typedef struct packed {
        logic clearInputImage;
        logic readInputImage;
        logic runStartup;
        logic runMain;
        logic writeOutputImage;
        logic clearOutputImage;
        logic eraseUser;
        logic freezeTimers;
    } pmrc_seq_t;
endpackage

// *** pmrc_ctrl.sv ***
// Purpose: Operating mode and reset supervisor of a controller CPU.
// Assumes: Program engine, memories and I/O report over the strobes here.
// Notes: Software drives the block over APB; zero-wait slave.
// Summary of operation
// - Breakpoint hit in RUN enters HOLD, regs shown
// - HOLD: run LED blinks, stop LED steady
// - HOLD halts all levels, timers frozen, clock runs
// - HOLD asserts output inhibit, links stay up
// - HOLD advances one statement or to breakpoint
// - Single step refused above two breakpoints
// - At most three breakpoints defined
// - 100 ms watchdog forces defined STOP
// - Cycle limit, at least 1 ms, forces STOP
// - RUN to STOP asserts output inhibit
// - Analog mode register picks safe or substitute values, safe at reset
// - Startup: clear inputs, startup, clear outputs, release
// - Startup reads remote inputs once
// - RUN cycles read inputs, main, write outputs
// - Overall reset erases user memory, not card
// - Hold switch at reset three seconds, LED steady
// - Tap within three seconds, blink then steady
// - Station reset in STOP blinks then steady
// - Reload project file with card LED lit
// - Factory reset clears RAM, address back to 2
// - Power-on STOP flags differing firmware package
// - Packages named px plus six digits
// - Firmware install performs overall reset
`include "pmrc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pmrc_ctrl #(
    parameter int unsigned WDOG_CYCLES = `PMRC_WDOG_MS * (`PMRC_CLK_HZ / 1000),
    parameter int unsigned WIPE_CYCLES = `PMRC_HOLD_WIPE_S * `PMRC_CLK_HZ,
    parameter int unsigned TAP_CYCLES = `PMRC_TAP_MAX_S * `PMRC_CLK_HZ,
    parameter int unsigned BLINK_CYCLES = `PMRC_BLINK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] modeSwitch,
    output pmrc_pkg::pmrc_leds_t leds,
    output logic outputInhibit,
    output pmrc_pkg::pmrc_seq_t seq,
    output logic [1:0] analogMode,
    output logic [7:0] multipointInterfaceAddress
);
    // Switch comes from a pin: two flops before use.
    logic [1:0] swMeta_reg;
    logic [1:0] swSync_reg;
    pmrc_pkg::pmrc_state_t state_reg, state_next;
    logic [31:0] cnt_reg;
    logic [31:0] wdog_reg;
    logic [31:0] cyc_reg;
    logic [31:0] blink_reg;
    logic blinkPhase_reg;
    logic [1:0] bkptCount_reg;
    logic [15:0] cycLimitMs_reg;
    logic [1:0] analog_reg;
    logic [7:0] mpa_reg;
    logic cardReload_reg;
    logic [15:0] cardPrefix_reg;
    logic [23:0] cardNum_reg;
    logic [23:0] fwInstalled_reg;
    logic fwAvail_reg;
    logic powerOn_reg;
    logic factory_reg;
    logic stepPending_reg;
    logic stepRefused_reg;
    logic wdogTrip_reg;
    logic cycTrip_reg;
    logic [31:0] prdata_reg;
    logic [2:0] phase_reg;

    wire logic wrEn = psel & penable & pwrite;
    wire logic rdEn = psel & penable & ~pwrite;
    wire logic wrCmd = wrEn && paddr == `PMRC_OFS_CMD;
    wire logic cmdStep = wrCmd & pwdata[`PMRC_CMD_STEP];
    wire logic cmdResume = wrCmd & pwdata[`PMRC_CMD_RESUME];
    wire logic cmdWipe = wrCmd & pwdata[`PMRC_CMD_WIPE];
    wire logic cmdFactory = wrCmd & pwdata[`PMRC_CMD_FACTORY];
    wire logic cmdFw = wrCmd & pwdata[`PMRC_CMD_FWUPD];
    wire logic evBkHit = wrCmd & pwdata[`PMRC_CMD_BKHIT];
    wire logic evCycDone = wrCmd & pwdata[`PMRC_CMD_CYCDONE];
    wire logic evKick = wrCmd & pwdata[`PMRC_CMD_WDKICK];
    wire logic evReloaded = wrCmd & pwdata[`PMRC_CMD_RELOADED];
    wire logic evStartDone = wrCmd & pwdata[`PMRC_CMD_STARTDONE];
    wire logic swWipe = swSync_reg == pmrc_pkg::SW_WIPE;
    wire logic swRun = swSync_reg == pmrc_pkg::SW_RUN;
    wire logic [31:0] cycLimit = 32'(cycLimitMs_reg) * `PMRC_CYC_MS_CYCLES;
    wire logic wdogExpire = wdog_reg >= WDOG_CYCLES - 1;
    wire logic cycExpire = cyc_reg >= cycLimit - 32'h1;
    // Refused steps leave HOLD untouched and set a sticky status bit.
    wire logic stepOk = bkptCount_reg <= `PMRC_STEP_BKPT_MAX;
    wire logic pkgNamed = cardPrefix_reg == `PMRC_FW_PREFIX;
    wire logic inRun = state_reg == pmrc_pkg::ST_RUN;
    wire logic inHold = state_reg == pmrc_pkg::ST_HOLD;
    wire logic inStop = state_reg == pmrc_pkg::ST_STOP;
    wire logic eraseDone = cnt_reg == `PMRC_ERASE_CYCLES - 1;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            swMeta_reg <= 2'h0;
            swSync_reg <= 2'h0;
        end
        else
        begin
            swMeta_reg <= modeSwitch;
            swSync_reg <= swMeta_reg;
        end
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            pmrc_pkg::ST_STOP:
            begin
                if (cmdFw && fwAvail_reg)
                    state_next = pmrc_pkg::ST_FWUPD;
                else if (cmdWipe || cmdFactory)
                    state_next = pmrc_pkg::ST_ERASE;
                else if (swWipe && cnt_reg >= WIPE_CYCLES - 1)
                    state_next = pmrc_pkg::ST_ARM;
                else if (swRun && !wdogTrip_reg && !cycTrip_reg)
                    state_next = pmrc_pkg::ST_STARTUP;
            end
            pmrc_pkg::ST_STARTUP:
            begin
                if (!swRun)
                    state_next = pmrc_pkg::ST_STOP;
                else if (evStartDone && phase_reg == 3'h2)
                    state_next = pmrc_pkg::ST_RUN;
            end
            pmrc_pkg::ST_RUN:
            begin
                if (!swRun || wdogExpire || cycExpire)
                    state_next = pmrc_pkg::ST_STOP;
                else if ((evBkHit && bkptCount_reg != 2'h0) ||
                    stepPending_reg)
                    state_next = pmrc_pkg::ST_HOLD;
            end
            pmrc_pkg::ST_HOLD:
            begin
                if (!swRun)
                    state_next = pmrc_pkg::ST_STOP;
                else if ((cmdStep && stepOk) || cmdResume)
                    state_next = pmrc_pkg::ST_RUN;
            end
            pmrc_pkg::ST_ARM:
            begin
                if (!swWipe)
                    state_next = pmrc_pkg::ST_WAITTAP;
            end
            pmrc_pkg::ST_WAITTAP:
            begin
                if (swWipe)
                    state_next = pmrc_pkg::ST_ERASE;
                else if (cnt_reg >= TAP_CYCLES - 1)
                    state_next = pmrc_pkg::ST_STOP;
            end
            pmrc_pkg::ST_ERASE:
            begin
                if (eraseDone)
                    state_next = cardReload_reg ? pmrc_pkg::ST_RELOAD
                                                : pmrc_pkg::ST_STOP;
            end
            pmrc_pkg::ST_RELOAD:
            begin
                if (evReloaded)
                    state_next = pmrc_pkg::ST_STOP;
            end
            pmrc_pkg::ST_FWUPD:
            begin
                if (eraseDone)
                    state_next = pmrc_pkg::ST_ERASE;
            end
            default:
                state_next = pmrc_pkg::ST_STOP;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= pmrc_pkg::ST_STOP;
            cnt_reg <= 32'h0;
            phase_reg <= 3'h0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_next != state_reg)
                cnt_reg <= 32'h0;
            else if ((inStop && !swWipe) || (inRun))
                cnt_reg <= 32'h0;
            else
                cnt_reg <= cnt_reg + 32'h1;
            // Startup phases: clear inputs, read inputs, startup, then main loop.
            if (state_reg != pmrc_pkg::ST_STARTUP)
                phase_reg <= 3'h0;
            else if (phase_reg < 3'h2)
                phase_reg <= phase_reg + 3'h1;
        end
    end

    // Watchdog and cycle monitor restart on each kick or finished cycle.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wdog_reg <= 32'h0;
            cyc_reg <= 32'h0;
        end
        else
        begin
            wdog_reg <= (!inRun || evKick) ? 32'h0 : wdog_reg + 32'h1;
            cyc_reg <= (!inRun || evCycDone) ? 32'h0 : cyc_reg + 32'h1;
        end
    end

    // Software register writes; status events set wins over clear.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bkptCount_reg <= 2'h0;
            cycLimitMs_reg <= 16'h0064;
            analog_reg <= 2'h0;
            mpa_reg <= `PMRC_MPA_DEFAULT;
            stepPending_reg <= 1'b0;
            cardReload_reg <= 1'b0;
            cardPrefix_reg <= 16'h0;
            cardNum_reg <= 24'h0;
            fwInstalled_reg <= 24'h0;
            stepRefused_reg <= 1'b0;
            wdogTrip_reg <= 1'b0;
            cycTrip_reg <= 1'b0;
            factory_reg <= 1'b0;
        end
        else
        begin
            if (wrEn && paddr == `PMRC_OFS_BKPT)
                bkptCount_reg <= (pwdata > 32'(`PMRC_MAX_BKPT))
                    ? `PMRC_MAX_BKPT : pwdata[1:0];
            if (wrEn && paddr == `PMRC_OFS_CYCLIM)
                cycLimitMs_reg <= (pwdata[15:0] < 16'h0001)
                    ? 16'h0001 : pwdata[15:0];
            if (wrEn && paddr == `PMRC_OFS_ANALOG)
                analog_reg <= pwdata[1:0];
            if (wrEn && paddr == `PMRC_OFS_CARD)
            begin
                cardReload_reg <= pwdata[0];
                cardPrefix_reg <= pwdata[31:16];
            end
            if (wrEn && paddr == `PMRC_OFS_FWVER)
                cardNum_reg <= pwdata[23:0];
            if (cmdFactory && inStop)
                factory_reg <= 1'b1;
            else if (state_reg == pmrc_pkg::ST_ERASE && eraseDone)
                factory_reg <= 1'b0;
            if (factory_reg && eraseDone)
                mpa_reg <= `PMRC_MPA_DEFAULT;
            else if (wrEn && paddr == `PMRC_OFS_MPA)
                mpa_reg <= pwdata[7:0];
            if (state_reg == pmrc_pkg::ST_FWUPD && eraseDone)
                fwInstalled_reg <= cardNum_reg;
            stepPending_reg <= inHold && cmdStep && stepOk;
            if (inHold && cmdStep && !stepOk)
                stepRefused_reg <= 1'b1;
            else if (wrEn && paddr == `PMRC_OFS_STAT && pwdata[0])
                stepRefused_reg <= 1'b0;
            if (inRun && wdogExpire)
                wdogTrip_reg <= 1'b1;
            else if (wrEn && paddr == `PMRC_OFS_STAT && pwdata[1])
                wdogTrip_reg <= 1'b0;
            if (inRun && cycExpire)
                cycTrip_reg <= 1'b1;
            else if (wrEn && paddr == `PMRC_OFS_STAT && pwdata[2])
                cycTrip_reg <= 1'b0;
        end
    end

    // Package check is re-taken each cycle in STOP with the run switch off, from power-on until STOP is first left.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            powerOn_reg <= 1'b1;
            fwAvail_reg <= 1'b0;
        end
        else
        begin
            if (powerOn_reg && inStop && !swRun)
                fwAvail_reg <= pkgNamed &&
                    cardNum_reg != fwInstalled_reg;
            else if (state_reg == pmrc_pkg::ST_FWUPD)
                fwAvail_reg <= 1'b0;
            if (!inStop)
                powerOn_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            blink_reg <= 32'h0;
            blinkPhase_reg <= 1'b0;
        end
        else if (blink_reg >= BLINK_CYCLES - 1)
        begin
            blink_reg <= 32'h0;
            blinkPhase_reg <= ~blinkPhase_reg;
        end
        else
            blink_reg <= blink_reg + 32'h1;
    end

    // Output inhibit is high everywhere but RUN, so HOLD and STOP both drop
    // the outputs; communication links are not touched by this block.
    assign outputInhibit = !inRun;
    assign analogMode = analog_reg;
    assign multipointInterfaceAddress = mpa_reg;

    always_comb
    begin
        leds.runLed = inRun | (inHold & blinkPhase_reg);
        leds.stopLed = inHold | (inStop & ~swWipe) |
            (state_reg == pmrc_pkg::ST_ARM) |
            (state_reg == pmrc_pkg::ST_WAITTAP) |
            ((state_reg == pmrc_pkg::ST_ERASE) & blinkPhase_reg) |
            (inStop & swWipe & blinkPhase_reg);
        leds.cardLed = state_reg == pmrc_pkg::ST_RELOAD;
        leds.fwLed = fwAvail_reg & blinkPhase_reg;
    end

    always_comb
    begin
        seq = '0;
        seq.freezeTimers = inHold;
        seq.eraseUser = state_reg == pmrc_pkg::ST_ERASE;
        seq.clearInputImage = state_reg == pmrc_pkg::ST_STARTUP &&
            phase_reg == 3'h0;
        seq.readInputImage = (state_reg == pmrc_pkg::ST_STARTUP &&
            phase_reg == 3'h1) || (inRun && evCycDone);
        seq.runStartup = state_reg == pmrc_pkg::ST_STARTUP &&
            phase_reg == 3'h2;
        seq.runMain = inRun;
        seq.writeOutputImage = inRun && evCycDone;
        seq.clearOutputImage = state_reg == pmrc_pkg::ST_STARTUP &&
            state_next == pmrc_pkg::ST_RUN;
    end

    always_comb
    begin
        case (paddr)
            `PMRC_OFS_CTRL: prdata_reg = {23'h0, state_reg};
            `PMRC_OFS_STAT: prdata_reg = {27'h0, fwAvail_reg, inHold,
                cycTrip_reg, wdogTrip_reg, stepRefused_reg};
            `PMRC_OFS_BKPT: prdata_reg = {30'h0, bkptCount_reg};
            `PMRC_OFS_CYCLIM: prdata_reg = {16'h0, cycLimitMs_reg};
            `PMRC_OFS_ANALOG: prdata_reg = {30'h0, analog_reg};
            `PMRC_OFS_CARD: prdata_reg = {cardPrefix_reg, 15'h0,
                cardReload_reg};
            `PMRC_OFS_MPA: prdata_reg = {24'h0, mpa_reg};
            `PMRC_OFS_FWVER: prdata_reg = {8'h0, fwInstalled_reg};
            default: prdata_reg = 32'h0;
        endcase
    end

    assign prdata = rdEn ? prdata_reg : 32'h0;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    a_hold_inhibit: assert property (@(posedge clk) disable iff (!rstn)
        inHold |-> outputInhibit && seq.freezeTimers)
        else $error("Hold without inhibit or frozen timers.");
    a_step_refused: assert property (@(posedge clk) disable iff (!rstn)
        inHold && cmdStep && bkptCount_reg == 2'h3 && !cmdResume
        |=> inHold)
        else $error("Step accepted with three breakpoints.");
    a_bkpt_enter: assert property (@(posedge clk) disable iff (!rstn)
        inRun && swRun && evBkHit && bkptCount_reg != 2'h0 && !wdogExpire
        && !cycExpire |=> inHold)
        else $error("Breakpoint did not enter hold.");
    a_wdog_stop: assert property (@(posedge clk) disable iff (!rstn)
        inRun && wdog_reg == WDOG_CYCLES - 1 |=> inStop)
        else $error("Watchdog expiry did not stop.");
    a_bkpt_max: assert property (@(posedge clk) disable iff (!rstn)
        wrEn && paddr == `PMRC_OFS_BKPT && pwdata > 32'h00000003
        |=> bkptCount_reg == 2'h3)
        else $error("Breakpoint count above limit.");
    a_hold_leds: assert property (@(posedge clk) disable iff (!rstn)
        inHold |-> leds.stopLed && leds.runLed == blinkPhase_reg)
        else $error("Hold indicators wrong.");
    a_cyc_min: assert property (@(posedge clk) disable iff (!rstn)
        cycLimitMs_reg >= 16'h0001)
        else $error("Cycle limit below one millisecond.");
    a_run_inhibit: assert property (@(posedge clk) disable iff (!rstn)
        inRun ##1 !inRun |-> outputInhibit)
        else $error("Leaving run left outputs enabled.");
    a_factory_addr: assert property (@(posedge clk) disable iff (!rstn)
        factory_reg && eraseDone && state_reg == pmrc_pkg::ST_ERASE
        |=> mpa_reg == `PMRC_MPA_DEFAULT)
        else $error("Factory reset kept the address.");
endmodule
`default_nettype wire

// *** pmrc_partner.sv ***
// Purpose: Operator switch and programming station facing the supervisor.
// Assumes: The slave may stretch the access phase with pready.
// Notes: Idle address and data lines are inverted so stale values are never trusted.
`timescale 1ns/1ps
`default_nettype none
module pmrc_partner (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    output logic [1:0] modeSwitch
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        modeSwitch = pmrc_pkg::SW_STOP;
    end
    // Step and resume requests travel as ordinary writes.
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        #1;
    endtask
    // Long holds arm the reset, set by the caller.
    task automatic set_switch(input logic [1:0] s);
        @(posedge clk);
        modeSwitch <= s;
    endtask
    // A quick tap, well inside the confirm window.
    task automatic tap_wipe();
        set_switch(pmrc_pkg::SW_STOP);
        repeat (2) @(posedge clk);
        modeSwitch <= pmrc_pkg::SW_WIPE;
        repeat (4) @(posedge clk);
        modeSwitch <= pmrc_pkg::SW_STOP;
    endtask
endmodule
`default_nettype wire

// *** tb_plc_mode_reset_controller.sv ***
// Purpose: Self-checking bench of the mode and reset supervisor.
// Assumes: Small count parameters stand in for the real seconds.
// Notes: The state word is polled in wait_state; some checks read it after a fixed delay.
`include "pmrc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_plc_mode_reset_controller;
    logic clk;
    logic rstn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic [1:0] modeSwitch;
    pmrc_pkg::pmrc_leds_t leds;
    logic outputInhibit;
    pmrc_pkg::pmrc_seq_t seq;
    logic [1:0] analogMode;
    logic [7:0] mpaAddr;
    int numErrors = 0;
    int checked = 0;
    int clrOut = 0;
    int wrOut = 0;
    pmrc_ctrl #(.WDOG_CYCLES(50), .WIPE_CYCLES(20), .TAP_CYCLES(20),
        .BLINK_CYCLES(4)) i_pmrc_ctrl (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(), .modeSwitch(modeSwitch),
        .leds(leds), .outputInhibit(outputInhibit), .seq(seq),
        .analogMode(analogMode), .multipointInterfaceAddress(mpaAddr));
    pmrc_partner i_pmrc_partner (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .modeSwitch(modeSwitch));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
        if (seq.clearOutputImage === 1'b1) clrOut++;
    always @(posedge clk)
        if (seq.writeOutputImage === 1'b1) wrOut++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string msg);
        checked++;
        if (got !== exp)
        begin
            numErrors++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_pmrc_partner.apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        i_pmrc_partner.apb(1'b0, a, 32'h0, q);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e,
        input string m);
        logic [31:0] q;
        rd(a, q);
        chk(q, e, m);
    endtask
    task automatic statbit(input int b, input logic e, input string m);
        logic [31:0] q;
        rd(`PMRC_OFS_STAT, q);
        chk({31'h0, q[b]}, {31'h0, e}, m);
    endtask
    task automatic wait_state(input logic [31:0] e, input int n,
        input string m);
        logic [31:0] q;
        rd(`PMRC_OFS_CTRL, q);
        while (q !== e && n > 0)
        begin
            rd(`PMRC_OFS_CTRL, q);
            n--;
        end
        chk(q, e, m);
    endtask
    task automatic wait_seq(input int b, input string m);
        int t;
        t = 0;
        while (seq[b] !== 1'b1 && t < 100)
        begin
            @(posedge clk);
            #1;
            t++;
        end
        chk({31'h0, seq[b]}, 32'h1, m);
    endtask
    // Led bits: 3 run, 2 stop, 1 card, 0 firmware.
    task automatic led8(input int b, input logic blinks, input string m);
        int t;
        logic p;
        t = 0;
        p = leds[b];
        repeat (8)
        begin
            @(posedge clk);
            #1;
            if (leds[b] !== p || leds[b] !== 1'b1) t++;
            p = leds[b];
        end
        chk({31'h0, t > 0}, {31'h0, blinks}, m);
    endtask
    task automatic t_reset();
        rchk(`PMRC_OFS_CTRL, 32'h1, "state after reset");
        chk({31'h0, outputInhibit}, 32'h1, "inhibit in stop");
        led8(2, 1'b0, "stop led on");
        rchk(`PMRC_OFS_MPA, 32'h2, "mpa reset");
        rchk(`PMRC_OFS_CYCLIM, 32'd100, "cycle limit reset");
        wr(`PMRC_OFS_CYCLIM, 32'h0);
        rchk(`PMRC_OFS_CYCLIM, 32'h1, "cycle limit floor");
        wr(12'h024, 32'hffffffff);
        rchk(12'h024, 32'h0, "unmapped read");
        wr(`PMRC_OFS_ANALOG, 32'h1);
        chk({30'h0, analogMode}, 32'h1, "substitute mode");
        wr(`PMRC_OFS_ANALOG, 32'h0);
        chk({30'h0, analogMode}, 32'h0, "safe defaults");
        $display("test reset done");
    endtask
    task automatic t_station();
        wr(`PMRC_OFS_CARD, 32'h70780000);
        wr(`PMRC_OFS_CMD, 32'h4);
        wait_seq(1, "erase active");
        led8(2, 1'b1, "stop blinks in erase");
        wait_state(32'h1, 100, "back to stop");
        led8(2, 1'b0, "stop steady after");
        rchk(`PMRC_OFS_CARD, 32'h70780000, "card untouched");
        $display("test station reset done");
    endtask
    task automatic t_switch();
        wr(`PMRC_OFS_CARD, 32'h70780001);
        i_pmrc_partner.set_switch(pmrc_pkg::SW_WIPE);
        led8(2, 1'b1, "stop blinks while held");
        repeat (18) @(posedge clk);
        led8(2, 1'b0, "armed stop steady");
        i_pmrc_partner.tap_wipe();
        wait_state(32'h80, 150, "reload entered");
        chk({31'h0, leds.cardLed}, 32'h1, "card led lit");
        wr(`PMRC_OFS_CMD, 32'h100);
        wait_state(32'h1, 20, "stop after reload");
        chk({31'h0, leds.cardLed}, 32'h0, "card led off");
        wr(`PMRC_OFS_CARD, 32'h70780000);
        $display("test switch reset done");
    endtask
    task automatic t_fw();
        logic [31:0] v;
        rd(`PMRC_OFS_FWVER, v);
        wr(`PMRC_OFS_CARD, 32'h70780000);
        wr(`PMRC_OFS_FWVER, v);
        statbit(4, 1'b0, "same version");
        wr(`PMRC_OFS_CARD, 32'h12340000);
        wr(`PMRC_OFS_FWVER, v + 32'h1);
        statbit(4, 1'b0, "foreign prefix");
        wr(`PMRC_OFS_CARD, 32'h70780000);
        statbit(4, 1'b1, "update offered");
        led8(0, 1'b1, "fw led blinks");
        wr(`PMRC_OFS_CMD, 32'h10);
        wait_seq(1, "install erases");
        wait_state(32'h1, 300, "stop after install");
        $display("test firmware done");
    endtask
    task automatic t_factory();
        wr(`PMRC_OFS_MPA, 32'h9);
        rchk(`PMRC_OFS_MPA, 32'h9, "mpa written");
        wr(`PMRC_OFS_CMD, 32'h8);
        wait_state(32'h1, 300, "stop after factory");
        rchk(`PMRC_OFS_MPA, 32'h2, "mpa default");
        chk({24'h0, mpaAddr}, 32'h2, "mpa pins");
        $display("test factory done");
    endtask
    task automatic t_startup();
        int c;
        i_pmrc_partner.set_switch(pmrc_pkg::SW_RUN);
        wait_seq(7, "inputs cleared");
        wait_seq(6, "remote inputs read");
        wait_seq(5, "startup runs");
        chk({31'h0, outputInhibit}, 32'h1, "inhibit in startup");
        c = clrOut;
        wr(`PMRC_OFS_CMD, 32'h200);
        chk({31'h0, clrOut != c}, 32'h1, "outputs cleared");
        rchk(`PMRC_OFS_CTRL, 32'h4, "run entered");
        chk({31'h0, outputInhibit}, 32'h0, "inhibit released");
        wait_seq(4, "main runs");
        c = wrOut;
        wr(`PMRC_OFS_CMD, 32'h40);
        chk({31'h0, wrOut != c}, 32'h1, "outputs written");
        $display("test startup done");
    endtask
    task automatic t_hold();
        wr(`PMRC_OFS_BKPT, 32'h1);
        wr(`PMRC_OFS_CMD, 32'h20);
        rchk(`PMRC_OFS_CTRL, 32'h8, "hold entered");
        statbit(3, 1'b1, "hold flag");
        chk({31'h0, outputInhibit}, 32'h1, "inhibit in hold");
        chk({31'h0, seq.freezeTimers}, 32'h1, "timers frozen");
        chk({31'h0, seq.runMain}, 32'h0, "no execution");
        led8(3, 1'b1, "run blinks");
        led8(2, 1'b0, "stop steady");
        wr(`PMRC_OFS_CMD, 32'h1);
        wait_state(32'h8, 5, "back in hold");
        statbit(0, 1'b0, "step allowed");
        wr(`PMRC_OFS_BKPT, 32'h3);
        wr(`PMRC_OFS_CMD, 32'h1);
        statbit(0, 1'b1, "step refused");
        wr(`PMRC_OFS_BKPT, 32'h4);
        rchk(`PMRC_OFS_BKPT, 32'h3, "three at most");
        wr(`PMRC_OFS_CMD, 32'h2);
        wait_state(32'h4, 5, "resumed");
        $display("test hold done");
    endtask
    task automatic t_wdog();
        wr(`PMRC_OFS_CMD, 32'h80);
        repeat (38) @(posedge clk);
        rchk(`PMRC_OFS_CTRL, 32'h4, "kicked run");
        wait_state(32'h1, 40, "watchdog stop");
        statbit(1, 1'b1, "watchdog flag");
        chk({31'h0, outputInhibit}, 32'h1, "inhibit set");
        wr(`PMRC_OFS_STAT, 32'h2);
        statbit(1, 1'b0, "flag cleared");
        i_pmrc_partner.set_switch(pmrc_pkg::SW_STOP);
        $display("test watchdog done");
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        numErrors++;
        end_sim();
    end
    initial
    begin
        rstn = 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_fw();
        t_station();
        t_switch();
        t_factory();
        t_startup();
        t_hold();
        t_wdog();
        end_sim();
    end
endmodule
`default_nettype wire
